// [tb/crhbp_host_model.sv]
`timescale 1ns/1ns
module crhbp_host_model (
  // Clock
  input  logic       core_clk,
  // Host bus pins
  output logic [7:0] busDataIn,
  input  logic [7:0] busDataOut,
  input  logic       busDataOe,
  output logic [3:0] regAddrPins,
  output logic       rdN,
  output logic       wrN,
  output logic       csN,
  output logic       ale
);
  // ==========
  // Bus wire
  logic [7:0] hostData = 8'h00;
  logic       hostOe = 1'b0;
  logic [7:0] lastBus = 8'h00;
  int         hold = 5;
  // Released lines toggle every cycle
  assign busDataIn = busDataOe ? busDataOut : (hostOe ? hostData : ~lastBus);
  always @(posedge core_clk) lastBus <= busDataIn;
  initial
  begin
    regAddrPins = 4'h0;
    rdN = 1'b1;
    wrN = 1'b1;
    csN = 1'b1;
    ale = 1'b0;
  end
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // ==========
  // One access; en low leaves the write strobe idle in nonmultiplexed accesses
  task automatic access(input bit mux, input bit wr, input bit en, input logic [3:0] addr, input logic [7:0] data);
    hostOe = 1'b1;
    if (mux)
    begin
      hostData = {4'h0, addr};
      regAddrPins = ~addr;
      csN = 1'b0;
      ale = 1'b1;
      idle(3);
      ale = 1'b0;
      idle(2);
    end
    else
    begin
      regAddrPins = addr;
      rdN = !wr;
      idle(1);
    end
    hostOe = wr;
    hostData = data;
    csN = 1'b0;
    rdN = mux ? wr : !wr;
    wrN = mux ? !wr : !en;
    idle(hold);
    wrN = 1'b1;
    if (mux)
      rdN = 1'b1;
    idle(4);
    csN = 1'b1;
    rdN = 1'b1;
    hostOe = 1'b0;
    idle(6);
  endtask
endmodule // crhbp_host_model

// [tb/crhbp_host_port_checker.sv]
`timescale 1ns/1ns
module crhbp_host_port_checker (
  // Clock and reset
  input logic                          core_clk,
  input logic                          rst_n,
  // Watched ports
  input logic [7:0]                    busDataOut,
  input logic                          busDataOe,
  input logic                          csN,
  input logic                          ale,
  input logic                          irqPending,
  input logic                          intN,
  input logic [7:0]                    uartTxHolding,
  input logic                          txHoldingLoad,
  input logic                          rxHoldingRead,
  input logic [2:0]                    cardSelBits,
  input logic                          uartSoftReset,
  input crhbp_pkg::crhbp_card_cfg_type selCardCfg,
  input logic [7:0]                    timeoutConfig,
  input logic                          busMuxMode
);
  // ==========
  // Port rules
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  irq_low_a: assert property (irqPending |=> !intN) else $error("int not low");
  irq_high_a: assert property (!irqPending |=> intN) else $error("int not high");
  read_sel_a: assert property (busDataOe |-> !$past(csN, 3)) else $error("drive unselected");
  bus_idle_a: assert property (!busDataOe |-> busDataOut == 8'h00) else $error("data while idle");
  mux_enter_a: assert property ($rose(ale) ##1 $stable(csN)[*5] |-> busMuxMode) else $error("no mux");
  mux_leave_a: assert property ($rose(csN) ##1 (!ale)[*5] |-> !busMuxMode) else $error("mux kept");
  tx_load_a: assert property ($changed(uartTxHolding) |-> txHoldingLoad) else $error("no load");
  rx_pulse_a: assert property (rxHoldingRead |=> !rxHoldingRead) else $error("long pulse");
  no_card_a: assert property ($stable(cardSelBits)[*2] ##0 !(cardSelBits inside {3'h1, 3'h2, 3'h4})
    |-> selCardCfg == '0) else $error("cfg without card");
  aux_power_a: assert property ($stable(cardSelBits)[*2] ##0 cardSelBits == 3'h4
    |-> selCardCfg.powerCtrl == 8'h00) else $error("aux power");
  srst_tout_a: assert property (uartSoftReset[*3] |-> timeoutConfig == 8'h00) else $error("timeout kept");
endmodule // crhbp_host_port_checker

bind crhbp_host_port crhbp_host_port_checker u_chk (.core_clk, .rst_n, .busDataOut, .busDataOe, .csN, .ale,
  .irqPending, .intN, .uartTxHolding, .txHoldingLoad, .rxHoldingRead, .cardSelBits, .uartSoftReset, .selCardCfg,
  .timeoutConfig, .busMuxMode);

// [tb/tb.sv]
`timescale 1ns/1ns
module tb;
  // ==========
  // Bench signals
  localparam logic [3:0] ID = 4'h9; // Arbitrary identification value
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic irqPending = 1'b0;
  logic [7:0] uartRxHolding = 8'h00;
  logic [7:0] busDataIn, busDataOut, uartTxHolding, timeoutConfig, e;
  logic [3:0] regAddrPins;
  logic [2:0] cardSelBits;
  logic busDataOe, rdN, wrN, csN, ale, intN, rxHoldingRead, txHoldingLoad, uartSoftReset, busMuxMode;
  logic oePrev = 1'b0;
  crhbp_pkg::crhbp_card_cfg_type selCardCfg;
  logic [7:0] expQ[$];
  logic [7:0] v[3][6];
  logic [3:0] ofs[6] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7};
  logic [7:0] msk[6] = '{8'h3f, 8'hff, 8'h7f, 8'hff, 8'hdf, 8'h3f};
  logic [2:0] sel[3] = '{3'h1, 3'h2, 3'h4};
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int loads = 0;
  int rxReads = 0;
  int muxCycles = 0;
  always #20 core_clk = ~core_clk;
  crhbp_host_port #(.DEVICE_ID(ID)) uut (.core_clk, .rst_n, .clkEn(1'b1), .busDataIn, .busDataOut, .busDataOe,
    .regAddrPins, .rdN, .wrN, .csN, .ale, .irqPending, .intN, .uartRxHolding, .rxHoldingRead, .uartTxHolding,
    .txHoldingLoad, .cardSelBits, .uartSoftReset, .selCardCfg, .timeoutConfig, .busMuxMode);
  crhbp_host_model host (.core_clk, .busDataIn, .busDataOut, .busDataOe, .regAddrPins, .rdN, .wrN, .csN, .ale);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input bit mux, input logic [3:0] a, input logic [7:0] x);
    expQ.push_back(x);
    host.access(mux, 1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic wr(input bit mux, input logic [3:0] a, input logic [7:0] d);
    host.access(mux, 1'b1, 1'b1, a, d);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========
  // Result watcher
  always @(posedge core_clk)
  begin
    oePrev <= busDataOe;
    loads <= loads + int'(txHoldingLoad === 1'b1);
    rxReads <= rxReads + int'(rxHoldingRead === 1'b1);
    muxCycles <= muxCycles + int'(busMuxMode === 1'b1);
    cycles <= cycles + 1;
    if (busDataOe === 1'b1 && oePrev !== 1'b1)
      chk(busDataOut, expQ.size() > 0 ? expQ.pop_front() : 8'hxx);
    if (cycles == 20000)
    begin
      num_errors++;
      give_verdict();
    end
  end
  // ==========
  // Main sequence
  initial
  begin
    void'($urandom(23164));
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    rd(0, 4'h0, {ID, 4'h0});
    for (int a = 1; a < 16; a++)
      if (a != 13)
        rd(0, 4'(a), 8'h00);
    chk(8'(muxCycles), 8'h00);
    $display("reset test done");
    for (int c = 0; c < 3; c++)
    begin
      wr(0, 4'h0, {5'h01, sel[c]});
      for (int r = 0; r < 6; r++)
      begin
        v[c][r] = 8'($urandom);
        wr(c == 1, ofs[r], v[c][r]);
      end
    end
    for (int c = 0; c < 3; c++)
    begin
      wr(c == 2, 4'h0, {5'h01, sel[c]});
      for (int r = 0; r < 6; r++)
      begin
        e = (c == 2 && r == 5) ? 8'h00 : v[c][r] & msk[r];
        rd(c == 0, ofs[r], e);
        chk(selCardCfg[47 - 8 * r -: 8], e);
      end
    end
    chk(8'(muxCycles > 0), 8'h01);
    chk({7'h00, busMuxMode}, 8'h00);
    $display("bank test done");
    host.hold = 9;
    uartRxHolding = 8'($urandom);
    rd(1, 4'hd, uartRxHolding);
    e = 8'($urandom);
    wr(0, 4'hd, e);
    chk(uartTxHolding, e);
    chk(8'(loads), 8'h01);
    chk(8'(rxReads), 8'h01);
    e = 8'($urandom) | 8'h01;
    wr(1, 4'h8, e);
    host.access(0, 1'b1, 1'b0, 4'h8, 8'h5a);
    host.access(0, 1'b0, 1'b0, 4'h8, 8'h00);
    rd(0, 4'h8, e);
    chk(timeoutConfig, e);
    $display("holding test done");
    irqPending = 1'b1;
    repeat (2) @(negedge core_clk);
    chk({7'h00, intN}, 8'h00);
    irqPending = 1'b0;
    repeat (2) @(negedge core_clk);
    chk({7'h00, intN}, 8'h01);
    $display("interrupt test done");
    wr(0, 4'h0, 8'h01);
    rd(0, 4'h0, {ID, 4'h1});
    chk({4'h0, uartSoftReset, cardSelBits}, 8'h09);
    rd(0, 4'h8, 8'h00);
    rd(0, 4'h7, (v[0][5] & 8'h3f) | 8'h30);
    rd(0, 4'h6, v[0][4] & 8'h53);
    chk(8'(expQ.size()), 8'h00);
    $display("soft reset test done");
    give_verdict();
  end
endmodule // tb

// [verilog/crhbp_consts.svh]
// Functional notes
// - Nonmultiplexed after reset until address strobe rises
// - Rising address strobe selects multiplexed mode
// - Reset or chip deselect returns nonmultiplexed
// - Falling address strobe latches low data nibble
// - Address latched regardless of chip select
// - Multiplexed access needs strobe and chip select
// - Nonmultiplexed address on dedicated address pins
// - Nonmultiplexed read strobe selects direction
// - Nonmultiplexed access needs write strobe, select
// - Five registers banked per three interfaces
// - Power control banked for A, B only
// - Banked access goes to selected card
// - Shared address: read receive, write transmit
// - Interrupt output low while pending
// - Four-bit address space, fixed register offsets
// - Card select bits one-hot encoded
// - Unimplemented bits ignore writes, read zero
`ifndef CRHBP_CONSTS_SVH
`define CRHBP_CONSTS_SVH

// ============================================================
// Register offsets
`define CRHBP_OFS_CARD_SELECT_CTRL  4'h0
`define CRHBP_OFS_CARD_CLOCK_CONFIG 4'h1
`define CRHBP_OFS_ETU_DIVIDER       4'h2
`define CRHBP_OFS_UART_CTRL_B       4'h3
`define CRHBP_OFS_GUARD_TIME        4'h5
`define CRHBP_OFS_UART_CTRL_A       4'h6
`define CRHBP_OFS_POWER_CTRL        4'h7
`define CRHBP_OFS_TIMEOUT_CONFIG    4'h8
`define CRHBP_OFS_UART_HOLDING      4'hd

// ============================================================
// Implemented-bit masks
`define CRHBP_MASK_CARD_CLOCK_CONFIG 8'h3f
`define CRHBP_MASK_UART_CTRL_B       8'h7f
`define CRHBP_MASK_UART_CTRL_A       8'hdf
`define CRHBP_MASK_POWER_CTRL        8'h3f
`define CRHBP_MASK_FULL              8'hff

// ============================================================
// Card select field layout
`define CRHBP_CSEL_ID_MSB    7
`define CRHBP_CSEL_ID_LSB    4
`define CRHBP_CSEL_SOFT_RST  3
`define CRHBP_CSEL_SEL_MSB   2
`define CRHBP_CSEL_SEL_LSB   0

// ============================================================
// One-hot card select codes
`define CRHBP_SEL_NONE 3'h0
`define CRHBP_SEL_A    3'h1
`define CRHBP_SEL_B    3'h2
`define CRHBP_SEL_AUX  3'h4

// ============================================================
// Reset values and soft-reset forcing
`define CRHBP_RST_ZERO            8'h00
`define CRHBP_RST_POWER_CTRL      8'h30
`define CRHBP_SRST_UART_A_KEEP    8'h73
`define CRHBP_SRST_POWER_SET      8'h30
`define CRHBP_SRST_POWER_KEEP     8'h0f

`endif

// [verilog/crhbp_host_port.sv]
`timescale 1ns/1ns
`include "crhbp_consts.svh"
module crhbp_host_port #(
  parameter int         CARDS      = 3,
  parameter int         PWR_CARDS  = 2,
  parameter logic [3:0] DEVICE_ID  = 4'h5  // Arbitrary identification value
) (
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          rst_n,
  input  wire logic                          clkEn,
  // Host parallel bus
  input  wire logic [7:0]                    busDataIn,
  output logic      [7:0]                    busDataOut,
  output logic                               busDataOe,
  input  wire logic [3:0]                    regAddrPins,
  input  wire logic                          rdN,
  input  wire logic                          wrN,
  input  wire logic                          csN,
  input  wire logic                          ale,
  // Interrupt
  input  wire logic                          irqPending,
  output logic                               intN,
  // Card core side
  input  wire logic [7:0]                    uartRxHolding,
  output logic                               rxHoldingRead,
  output logic [7:0]                         uartTxHolding,
  output logic                               txHoldingLoad,
  output logic [2:0]                         cardSelBits,
  output logic                               uartSoftReset,
  output crhbp_pkg::crhbp_card_cfg_type      selCardCfg,
  output logic [7:0]                         timeoutConfig,
  output logic                               busMuxMode
);

  initial
  begin
    if (CARDS != 3)
      $error("crhbp_host_port: CARDS must be 3 for one-hot select");
    if (PWR_CARDS < 1 || PWR_CARDS > CARDS)
      $error("crhbp_host_port: PWR_CARDS out of range");
  end

  // ============================================================
  // Synchronised inputs
  localparam int SYNC_W = 16;
  logic [SYNC_W-1:0]             syncBus;
  crhbp_pkg::crhbp_strobe_type   strobeNow;
  crhbp_pkg::crhbp_strobe_type   strobePrev_q;
  logic [7:0]                    dataNow;
  logic [3:0]                    addrPinsNow;
  logic [7:0]                    dataPrev_q;
  logic [3:0]                    addrPinsPrev_q;
  crhbp_pkg::crhbp_mode_type     mode;
  logic [3:0]                    muxAddr;
  crhbp_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clkEn    (clkEn),
    .asyncIn  ({~rdN, ~wrN, ~csN, ale, regAddrPins, busDataIn}),
    .syncOut  (syncBus)
  );
  assign strobeNow   = syncBus[15:12] ^ 4'he;  // Active-low strobes pass inverted so a reset stage reads idle
  assign addrPinsNow = syncBus[11:8];
  assign dataNow     = syncBus[7:0];
  crhbp_mode_detect u_mode (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .clkEn       (clkEn),
    .aleNow      (strobeNow.ale),
    .alePrev     (strobePrev_q.ale),
    .csNNow      (strobeNow.csN),
    .csNPrev     (strobePrev_q.csN),
    .addrNibble  (dataPrev_q[3:0]),
    .mode        (mode),
    .latchedAddr (muxAddr)
  );

  // ============================================================
  // Access decode
  logic       readActive;
  logic       writeActive;
  logic       writeActivePrev;
  logic       readActivePrev;
  logic       writeCommit;
  logic       readEnd;
  logic [3:0] accessAddr;
  logic [7:0] writeData;

  always_comb
  begin
    if (mode == crhbp_pkg::BUS_MUX)
    begin
      readActive      = ~strobeNow.csN & ~strobeNow.rdN;
      writeActive     = ~strobeNow.csN & ~strobeNow.wrN;
      readActivePrev  = ~strobePrev_q.csN & ~strobePrev_q.rdN;
      writeActivePrev = ~strobePrev_q.csN & ~strobePrev_q.wrN;
      accessAddr      = muxAddr;
    end
    else
    begin
      readActive      = ~strobeNow.csN & ~strobeNow.wrN & strobeNow.rdN;
      writeActive     = ~strobeNow.csN & ~strobeNow.wrN & ~strobeNow.rdN;
      readActivePrev  = ~strobePrev_q.csN & ~strobePrev_q.wrN & strobePrev_q.rdN;
      writeActivePrev = ~strobePrev_q.csN & ~strobePrev_q.wrN & ~strobePrev_q.rdN;
      accessAddr      = addrPinsPrev_q;
    end
    // Commit at end of write, using data held through the strobe
    writeCommit = clkEn & writeActivePrev & ~writeActive;
    readEnd     = clkEn & readActivePrev & ~readActive;
    writeData   = dataPrev_q;
  end

  // ============================================================
  // Register file
  logic [7:0] clockCfg_q   [CARDS];
  logic [7:0] clockCfg_d   [CARDS];
  logic [7:0] etuDiv_q     [CARDS];
  logic [7:0] etuDiv_d     [CARDS];
  logic [7:0] ctrlB_q      [CARDS];
  logic [7:0] ctrlB_d      [CARDS];
  logic [7:0] guard_q      [CARDS];
  logic [7:0] guard_d      [CARDS];
  logic [7:0] ctrlA_q      [CARDS];
  logic [7:0] ctrlA_d      [CARDS];
  logic [7:0] power_q      [PWR_CARDS];
  logic [7:0] power_d      [PWR_CARDS];
  logic       softRstN_q;
  logic       softRstN_d;
  logic [2:0] cardSel_q;
  logic [2:0] cardSel_d;
  logic [7:0] timeout_q;
  logic [7:0] timeout_d;
  logic [7:0] txHold_q;
  logic [7:0] txHold_d;
  logic       cardValid;
  int         cardIdx;

  always_comb
  begin
    // One-hot card select to bank index
    cardValid = 1'b1;
    cardIdx   = 0;
    case (cardSel_q)
      `CRHBP_SEL_A:   cardIdx = 0;
      `CRHBP_SEL_B:   cardIdx = 1;
      `CRHBP_SEL_AUX: cardIdx = 2;
      default:        cardValid = 1'b0;
    endcase
  end

  // Per-card banks, each with its own write decode
  genvar c;
  generate
    for (c = 0; c < CARDS; c++)
    begin : g_bank
      logic hit;
      always_comb
      begin
        hit           = writeCommit & cardValid & (cardIdx == c);
        clockCfg_d[c] = clockCfg_q[c];
        etuDiv_d[c]   = etuDiv_q[c];
        ctrlB_d[c]    = ctrlB_q[c];
        guard_d[c]    = guard_q[c];
        ctrlA_d[c]    = ctrlA_q[c];
        if (hit)
        begin
          case (accessAddr)
            `CRHBP_OFS_CARD_CLOCK_CONFIG: clockCfg_d[c] = writeData & `CRHBP_MASK_CARD_CLOCK_CONFIG;
            `CRHBP_OFS_ETU_DIVIDER:       etuDiv_d[c]   = writeData;
            `CRHBP_OFS_UART_CTRL_B:       ctrlB_d[c]    = writeData & `CRHBP_MASK_UART_CTRL_B;
            `CRHBP_OFS_GUARD_TIME:        guard_d[c]    = writeData;
            `CRHBP_OFS_UART_CTRL_A:       ctrlA_d[c]    = writeData & `CRHBP_MASK_UART_CTRL_A;
            default:                      ;
          endcase
        end
        // UART soft reset clears selected fields of the control bank
        if (clkEn & ~softRstN_q)
          ctrlA_d[c] = ctrlA_d[c] & `CRHBP_SRST_UART_A_KEEP;
      end

      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          clockCfg_q[c] <= `CRHBP_RST_ZERO;
          etuDiv_q[c]   <= `CRHBP_RST_ZERO;
          ctrlB_q[c]    <= `CRHBP_RST_ZERO;
          guard_q[c]    <= `CRHBP_RST_ZERO;
          ctrlA_q[c]    <= `CRHBP_RST_ZERO;
        end
        else
        begin
          clockCfg_q[c] <= clockCfg_d[c];
          etuDiv_q[c]   <= etuDiv_d[c];
          ctrlB_q[c]    <= ctrlB_d[c];
          guard_q[c]    <= guard_d[c];
          ctrlA_q[c]    <= ctrlA_d[c];
        end
      end
    end

    for (c = 0; c < PWR_CARDS; c++)
    begin : g_power
      always_comb
      begin
        power_d[c] = power_q[c];
        if (writeCommit & cardValid & (cardIdx == c) &
            (accessAddr == `CRHBP_OFS_POWER_CTRL))
          power_d[c] = writeData & `CRHBP_MASK_POWER_CTRL;
        if (clkEn & ~softRstN_q)
          power_d[c] = (power_d[c] & `CRHBP_SRST_POWER_KEEP) | `CRHBP_SRST_POWER_SET;
      end

      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
          power_q[c] <= `CRHBP_RST_POWER_CTRL;
        else
          power_q[c] <= power_d[c];
      end
    end
  endgenerate

  // ============================================================
  // Unbanked registers
  always_comb
  begin
    softRstN_d = softRstN_q;
    cardSel_d  = cardSel_q;
    timeout_d  = timeout_q;
    txHold_d   = txHold_q;
    if (writeCommit)
    begin
      case (accessAddr)
        `CRHBP_OFS_CARD_SELECT_CTRL:
        begin
          softRstN_d = writeData[`CRHBP_CSEL_SOFT_RST];
          cardSel_d  = writeData[`CRHBP_CSEL_SEL_MSB:`CRHBP_CSEL_SEL_LSB];
        end
        `CRHBP_OFS_TIMEOUT_CONFIG: timeout_d = writeData;
        `CRHBP_OFS_UART_HOLDING:   txHold_d  = writeData;
        default:                   ;
      endcase
    end
    if (clkEn & ~softRstN_q)
      timeout_d = `CRHBP_RST_ZERO;
  end
  // ============================================================
  // Read data and outputs
  logic [7:0]                    rdData;
  logic [7:0]                    dataOut_q;
  logic [7:0]                    dataOut_d;
  logic                          dataOe_q;
  logic                          dataOe_d;
  logic                          intN_q;
  logic                          intN_d;
  logic                          rxRead_q;
  logic                          rxRead_d;
  logic                          txLoad_q;
  logic                          txLoad_d;
  crhbp_pkg::crhbp_card_cfg_type selCfg_q;
  crhbp_pkg::crhbp_card_cfg_type selCfg_d;
  logic                          busMux_q;
  logic                          busMux_d;
  logic                          hasPower;

  always_comb
  begin
    hasPower = cardValid && (cardIdx < PWR_CARDS);
    rdData   = 8'h00;
    case (accessAddr)
      `CRHBP_OFS_CARD_SELECT_CTRL:  rdData = {DEVICE_ID, softRstN_q, cardSel_q};
      `CRHBP_OFS_CARD_CLOCK_CONFIG: rdData = cardValid ? clockCfg_q[cardIdx] : 8'h00;
      `CRHBP_OFS_ETU_DIVIDER:       rdData = cardValid ? etuDiv_q[cardIdx] : 8'h00;
      `CRHBP_OFS_UART_CTRL_B:       rdData = cardValid ? ctrlB_q[cardIdx] : 8'h00;
      `CRHBP_OFS_GUARD_TIME:        rdData = cardValid ? guard_q[cardIdx] : 8'h00;
      `CRHBP_OFS_UART_CTRL_A:       rdData = cardValid ? ctrlA_q[cardIdx] : 8'h00;
      `CRHBP_OFS_POWER_CTRL:        rdData = hasPower ? power_q[cardIdx] : 8'h00;
      `CRHBP_OFS_TIMEOUT_CONFIG:    rdData = timeout_q;
      `CRHBP_OFS_UART_HOLDING:      rdData = uartRxHolding;
      default:                      rdData = 8'h00;
    endcase

    dataOut_d = dataOut_q;
    dataOe_d  = dataOe_q;
    intN_d    = intN_q;
    rxRead_d  = 1'b0;
    txLoad_d  = 1'b0;
    selCfg_d  = selCfg_q;
    busMux_d  = busMux_q;
    if (clkEn)
    begin
      dataOe_d  = readActive;
      dataOut_d = readActive ? rdData : 8'h00;
      intN_d    = ~irqPending;
      rxRead_d  = readEnd & (accessAddr == `CRHBP_OFS_UART_HOLDING);
      txLoad_d  = writeCommit & (accessAddr == `CRHBP_OFS_UART_HOLDING);
      busMux_d  = (mode == crhbp_pkg::BUS_MUX);
      if (cardValid)
      begin
        selCfg_d.clockConfig = clockCfg_q[cardIdx];
        selCfg_d.etuDivider  = etuDiv_q[cardIdx];
        selCfg_d.uartCtrlB   = ctrlB_q[cardIdx];
        selCfg_d.guardTime   = guard_q[cardIdx];
        selCfg_d.uartCtrlA   = ctrlA_q[cardIdx];
        selCfg_d.powerCtrl   = hasPower ? power_q[cardIdx] : 8'h00;
      end
      else
        selCfg_d = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strobePrev_q   <= 4'hf;
      dataPrev_q     <= 8'h00;
      addrPinsPrev_q <= 4'h0;
      softRstN_q     <= 1'b0;
      cardSel_q      <= `CRHBP_SEL_NONE;
      timeout_q      <= `CRHBP_RST_ZERO;
      txHold_q       <= `CRHBP_RST_ZERO;
      dataOut_q      <= 8'h00;
      dataOe_q       <= 1'b0;
      intN_q         <= 1'b1;
      rxRead_q       <= 1'b0;
      txLoad_q       <= 1'b0;
      selCfg_q       <= '0;
      busMux_q       <= 1'b0;
    end
    else
    begin
      if (clkEn)
      begin
        strobePrev_q   <= strobeNow;
        dataPrev_q     <= dataNow;
        addrPinsPrev_q <= addrPinsNow;
      end
      softRstN_q <= softRstN_d;
      cardSel_q  <= cardSel_d;
      timeout_q  <= timeout_d;
      txHold_q   <= txHold_d;
      dataOut_q  <= dataOut_d;
      dataOe_q   <= dataOe_d;
      intN_q     <= intN_d;
      rxRead_q   <= rxRead_d;
      txLoad_q   <= txLoad_d;
      selCfg_q   <= selCfg_d;
      busMux_q   <= busMux_d;
    end
  end

  assign busDataOut    = dataOut_q;
  assign busDataOe     = dataOe_q;
  assign intN          = intN_q;
  assign rxHoldingRead = rxRead_q;
  assign uartTxHolding = txHold_q;
  assign txHoldingLoad = txLoad_q;
  assign cardSelBits   = cardSel_q;
  assign uartSoftReset = ~softRstN_q;
  assign selCardCfg    = selCfg_q;
  assign timeoutConfig = timeout_q;
  assign busMuxMode    = busMux_q;

endmodule // crhbp_host_port

// [verilog/crhbp_mode_detect.sv]
`timescale 1ns/1ns
`include "crhbp_consts.svh"
module crhbp_mode_detect (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic                   clkEn,
  // Synchronised bus view
  input  wire logic                   aleNow,
  input  wire logic                   alePrev,
  input  wire logic                   csNNow,
  input  wire logic                   csNPrev,
  input  wire logic [3:0]             addrNibble,
  // Result
  output crhbp_pkg::crhbp_mode_type   mode,
  output logic      [3:0]             latchedAddr
);

  crhbp_pkg::crhbp_mode_type mode_q;
  crhbp_pkg::crhbp_mode_type mode_d;
  logic [3:0]                addr_q;
  logic [3:0]                addr_d;
  logic [1:0]                primed_q;
  logic [1:0]                primed_d;
  logic                      aleRise;
  logic                      aleFall;
  logic                      csRelease;

  // ============================================================
  // Mode tracking and address latch
  always_comb
  begin
    aleRise   = aleNow & ~alePrev;
    aleFall   = ~aleNow & alePrev;
    csRelease = csNNow & ~csNPrev;
    mode_d    = mode_q;
    addr_d    = addr_q;
    primed_d  = primed_q;
    if (clkEn)
    begin
      // Edge history is unreliable until the synchroniser has filled
      if (primed_q != 2'h3)
        primed_d = primed_q + 2'h1;
      case (mode_q)
        crhbp_pkg::BUS_NONMUX:
        begin
          if (aleRise && primed_q == 2'h3)
            mode_d = crhbp_pkg::BUS_MUX;
        end
        crhbp_pkg::BUS_MUX:
        begin
          if (csRelease)
            mode_d = crhbp_pkg::BUS_NONMUX;
          if (aleFall)
            addr_d = addrNibble;
        end
        default:
          mode_d = crhbp_pkg::BUS_NONMUX;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_q <= crhbp_pkg::BUS_NONMUX;
      addr_q <= 4'h0;
      primed_q <= 2'h0;
    end
    else
    begin
      mode_q <= mode_d;
      addr_q <= addr_d;
      primed_q <= primed_d;
    end
  end

  assign mode        = mode_q;
  assign latchedAddr = addr_q;

endmodule // crhbp_mode_detect

// [verilog/crhbp_pkg.sv]
package crhbp_pkg;

  // Host port bus mode, Gray along idle->mux->idle
  typedef enum logic [1:0] {
    BUS_NONMUX = 2'b00,
    BUS_MUX    = 2'b01
  } crhbp_mode_type;

  // Settings of the selected card interface
  typedef struct packed {
    logic [7:0] clockConfig;
    logic [7:0] etuDivider;
    logic [7:0] uartCtrlB;
    logic [7:0] guardTime;
    logic [7:0] uartCtrlA;
    logic [7:0] powerCtrl;
  } crhbp_card_cfg_type;

  // Synchronised host strobes
  typedef struct packed {
    logic rdN;
    logic wrN;
    logic csN;
    logic ale;
  } crhbp_strobe_type;

endpackage

// [verilog/crhbp_sync.sv]
`timescale 1ns/1ns
module crhbp_sync #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             clkEn,
  // Data
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  initial
  begin
    if (WIDTH < 1)
      $error("crhbp_sync: WIDTH must be positive");
  end

  // ============================================================
  // Two-stage synchroniser per bit
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      logic stage1_q;
      logic stage1_d;
      logic stage2_q;
      logic stage2_d;

      always_comb
      begin
        stage1_d = clkEn ? asyncIn[i] : stage1_q;
        stage2_d = clkEn ? stage1_q : stage2_q;
      end

      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          stage1_q <= 1'b0;
          stage2_q <= 1'b0;
        end
        else
        begin
          stage1_q <= stage1_d;
          stage2_q <= stage2_d;
        end
      end

      assign syncOut[i] = stage2_q;
    end
  endgenerate

endmodule // crhbp_sync
